/* iwc_consts.vh */
// Constants for the interrupt and wake-up controller: register addresses,
// field positions, reset values, vector layout and timing counts.
// Assumes it is included by the controller file on its bare name.
`ifndef IWC_CONSTS_VH
`define IWC_CONSTS_VH

// Register addresses.
`define IWC_ADDR_POWER 8'h87
`define IWC_ADDR_EXTCTL 8'h88
`define IWC_ADDR_PINFLAG 8'h95
`define IWC_ADDR_WAKEMASK 8'h96
`define IWC_ADDR_EN_MAIN 8'hA8
`define IWC_ADDR_EN_EXTRA 8'hA9
`define IWC_ADDR_PLO_MAIN 8'hB8
`define IWC_ADDR_PHI_MAIN 8'hB9
`define IWC_ADDR_PLO_EXTRA 8'hBA
`define IWC_ADDR_PHI_EXTRA 8'hBB

// Field positions in power_control.
`define IWC_PWR_SLEEP 0
`define IWC_PWR_STOP 1
// Field positions in ext_int_control.
`define IWC_EXT_TRIG0 0
`define IWC_EXT_FLAG0 1
`define IWC_EXT_TRIG1 2
`define IWC_EXT_FLAG1 3
// Field positions in pin_flag_reg.
`define IWC_PF_TIMER3 0
`define IWC_PF_PORT 1
`define IWC_PF_PIN2 2
// Global enable bit.
`define IWC_EN_GLOBAL 7

// Reset values.
`define IWC_RST_BYTE 8'h00
`define IWC_RST_PINS 8'hFF

// Vector layout: address is slot times eight plus three.
`define IWC_VEC_LOW 3'h3
`define IWC_VEC_HIGH 8'h00
`define IWC_SRC_COUNT 9
// First source placed after the reserved slot.
`define IWC_SRC_AFTER_GAP 6

// Cycles requests stay held after Stop exit.
`define IWC_STOP_RESUME_CYC 4'h2

`endif

/* iwc_interrupt_wakeup_ctrl.v */
// Interrupt and wake-up controller for an 8051-style core: nine sources,
// four priority levels with nesting, Idle and Stop wake-up.
// Assumes pins and event inputs are synchronous to clk_sys, and that a
// clock generator restarts clk_sys from the stop_wake level.
`timescale 1ns/1ps
`include "iwc_consts.vh"

module iwc_interrupt_wakeup_ctrl
(
    // Clock and reset.
    input wire clk_sys,
    input wire reset,
    // Special-function register port from the core.
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    output reg [7:0] sfr_rdata,
    // Pins.
    input wire ext_pin0,
    input wire ext_pin1,
    input wire ext_pin2,
    input wire [7:0] p1_pins,
    // Peripheral event sources.
    input wire timer0_flag,
    input wire timer1_flag,
    input wire timer2_flag,
    input wire uart_flag,
    input wire timer3_event,
    input wire [3:0] timer_ctl_bits,
    // Handshake with the core.
    output wire int_req,
    output reg [15:0] int_vector,
    output reg [1:0] int_level,
    input wire int_ack,
    input wire int_return,
    output reg [8:0] src_ack,
    // Power mode outputs.
    output wire cpu_idle,
    output wire cpu_stop,
    output wire stop_wake,
    output wire [3:0] power_control_misc
);

    ////////////////////////////////////////////////////////////////////
    // Register state.

    // Power control: bits 1 and 0 are the mode requests.
    reg [7:0] power_reg;
    // Trigger selects and pin0/pin1 edge flags.
    reg [3:0] extctl_reg;
    // Pin2 flag, port change flag and timer3 flag.
    reg [2:0] pinflag_reg;
    // Port1 wake and change mask.
    reg [7:0] wake_mask_reg;
    // Enables, bit 7 of the main one is the global enable.
    reg [7:0] en_main_reg;
    reg [2:0] en_extra_reg;
    // Priority register pairs.
    reg [5:0] plo_main_reg;
    reg [5:0] phi_main_reg;
    reg [2:0] plo_extra_reg;
    reg [2:0] phi_extra_reg;
    // Previous pin levels for edge and change detection.
    reg pin0_prev_reg;
    reg pin1_prev_reg;
    reg pin2_prev_reg;
    reg [7:0] p1_prev_reg;
    // Port1 levels captured at each power register write, Stop entry among them.
    reg [7:0] p1_ref_reg;
    // One bit per level that has a handler in service.
    reg [3:0] in_service_reg;
    // Registered request and the source behind it.
    reg req_reg;
    reg [3:0] sel_src_reg;
    // Cycles left in which servicing stays held after Stop exit.
    reg [3:0] resume_reg;

    ////////////////////////////////////////////////////////////////////
    // Source vectors in vector order: pin0, timer0, pin1, timer1, uart,
    // timer2, timer3, port change, pin2.

    wire global_int_enable;
    wire pin0_trigger_select;
    wire pin1_trigger_select;
    wire pin0_int_enable;
    wire pin1_int_enable;
    wire pin2_int_enable;
    wire port_change_int_enable;
    wire pin0_fall;
    wire pin1_fall;
    wire pin2_fall;
    wire port_change;
    wire [8:0] src_pend;
    wire [8:0] src_en;
    wire [8:0] src_plo;
    wire [8:0] src_phi;
    wire [8:0] src_live;
    wire wr_power;
    wire stop_block;
    wire any_idle_wake;

    assign global_int_enable = en_main_reg[`IWC_EN_GLOBAL];
    assign pin0_trigger_select = extctl_reg[`IWC_EXT_TRIG0];
    assign pin1_trigger_select = extctl_reg[`IWC_EXT_TRIG1];
    assign pin0_int_enable = en_main_reg[0];
    assign pin1_int_enable = en_main_reg[2];
    assign pin2_int_enable = en_extra_reg[2];
    assign port_change_int_enable = en_extra_reg[1];

    // Falling edges on the external pins.
    assign pin0_fall = pin0_prev_reg & ~ext_pin0;
    assign pin1_fall = pin1_prev_reg & ~ext_pin1;
    assign pin2_fall = pin2_prev_reg & ~ext_pin2;
    // Any change of a masked Port1 pin.
    assign port_change = |((p1_pins ^ p1_prev_reg) & wake_mask_reg);

    // Pending requests; pin0 and pin1 follow their trigger select.
    assign src_pend = {
        pinflag_reg[`IWC_PF_PIN2],
        pinflag_reg[`IWC_PF_PORT],
        pinflag_reg[`IWC_PF_TIMER3],
        timer2_flag,
        uart_flag,
        timer1_flag,
        pin1_trigger_select ? extctl_reg[`IWC_EXT_FLAG1] : ~ext_pin1,
        timer0_flag,
        pin0_trigger_select ? extctl_reg[`IWC_EXT_FLAG0] : ~ext_pin0
    };

    // Per-source enables and priority bits in the same order.
    assign src_en = {en_extra_reg, en_main_reg[5:0]};
    assign src_plo = {plo_extra_reg, plo_main_reg};
    assign src_phi = {phi_extra_reg, phi_main_reg};

    // Servicing needs the global enable and the source enable.
    assign src_live = src_pend & src_en & {9{global_int_enable}};
    // Idle wake comes only from fully enabled sources.
    assign any_idle_wake = |src_live;

    ////////////////////////////////////////////////////////////////////
    // Arbitration over four levels.

    reg found;
    reg [1:0] best_lvl;
    reg [3:0] best_src;
    reg top_valid;
    reg [1:0] top_lvl;
    reg [1:0] lvl;
    reg [4:0] slot;
    integer i;

    // Scans downward so a lower index wins a tie.
    always @*
    begin
        found = 1'b0;
        best_lvl = 2'b00;
        best_src = 4'h0;
        lvl = 2'b00;
        for (i = `IWC_SRC_COUNT - 1; i >= 0; i = i - 1)
        begin
            lvl = {src_phi[i], src_plo[i]};
            if (src_live[i] && (!found || lvl >= best_lvl))
            begin
                found = 1'b1;
                best_lvl = lvl;
                best_src = i[3:0];
            end
        end
    end

    // Highest level that has a handler in service.
    always @*
    begin
        top_valid = |in_service_reg;
        if (in_service_reg[3])
            top_lvl = 2'b11;
        else if (in_service_reg[2])
            top_lvl = 2'b10;
        else if (in_service_reg[1])
            top_lvl = 2'b01;
        else
            top_lvl = 2'b00;
    end

    // Vector slot skips the reserved slot after timer2.
    always @*
    begin
        if (best_src < `IWC_SRC_AFTER_GAP)
            slot = {1'b0, best_src};
        else
            slot = {1'b0, best_src} + 5'h01;
    end

    // A request may go out only above every level in service.
    wire can_preempt;
    assign can_preempt = found && (!top_valid || best_lvl > top_lvl);
    wire ack_now;
    assign ack_now = int_ack & req_reg;

    // Request handshake is the registered arbitration result.
    assign int_req = req_reg;

    // Registers the winner; the cycle after an ack carries no request.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            req_reg <= 1'b0;
            sel_src_reg <= 4'h0;
            int_vector <= 16'h0000;
            int_level <= 2'b00;
        end
        else
        begin
            req_reg <= can_preempt && !ack_now && !stop_wake && ~|resume_reg;
            if (!ack_now)
            begin
                sel_src_reg <= best_src;
                int_vector <= {`IWC_VEC_HIGH, slot, `IWC_VEC_LOW};
                int_level <= best_lvl;
            end
        end
    end

    // In-service stack: set on ack, highest level cleared on return.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            in_service_reg <= 4'h0;
        else
        begin
            if (int_return)
            begin
                if (in_service_reg[3])
                    in_service_reg[3] <= 1'b0;
                else if (in_service_reg[2])
                    in_service_reg[2] <= 1'b0;
                else if (in_service_reg[1])
                    in_service_reg[1] <= 1'b0;
                else
                    in_service_reg[0] <= 1'b0;
            end
            if (ack_now)
                in_service_reg[int_level] <= 1'b1;
        end
    end

    // One-cycle clear pulse to the peripheral behind the vectored source.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            src_ack <= 9'h000;
        else if (ack_now)
            src_ack <= 9'h001 << sel_src_reg;
        else
            src_ack <= 9'h000;
    end

    ////////////////////////////////////////////////////////////////////
    // Pin history and flags.

    // Edge and change history; pins idle high.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pin0_prev_reg <= 1'b1;
            pin1_prev_reg <= 1'b1;
            pin2_prev_reg <= 1'b1;
            p1_prev_reg <= `IWC_RST_PINS;
        end
        else
        begin
            pin0_prev_reg <= ext_pin0;
            pin1_prev_reg <= ext_pin1;
            pin2_prev_reg <= ext_pin2;
            p1_prev_reg <= p1_pins;
        end
    end

    wire wr_ext;
    wire wr_flag;
    assign wr_ext = sfr_wr && sfr_addr == `IWC_ADDR_EXTCTL;
    assign wr_flag = sfr_wr && sfr_addr == `IWC_ADDR_PINFLAG;
    wire ack0;
    wire ack1;
    wire ack_t3;
    wire ack_port;
    wire ack_p2;
    assign ack0 = ack_now && sel_src_reg == 4'h0;
    assign ack1 = ack_now && sel_src_reg == 4'h2;
    assign ack_t3 = ack_now && sel_src_reg == 4'h6;
    assign ack_port = ack_now && sel_src_reg == 4'h7;
    assign ack_p2 = ack_now && sel_src_reg == 4'h8;

    // Trigger selects and pin0/pin1 edge flags; a set beats any clear.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            extctl_reg <= 4'h0;
        else
        begin
            extctl_reg[`IWC_EXT_TRIG0] <= wr_ext ?
                sfr_wdata[`IWC_EXT_TRIG0] : pin0_trigger_select;
            extctl_reg[`IWC_EXT_TRIG1] <= wr_ext ?
                sfr_wdata[`IWC_EXT_TRIG1] : pin1_trigger_select;
            if (pin0_fall)
                extctl_reg[`IWC_EXT_FLAG0] <= 1'b1;
            else if (ack0)
                extctl_reg[`IWC_EXT_FLAG0] <= 1'b0;
            else if (wr_ext)
                extctl_reg[`IWC_EXT_FLAG0] <= sfr_wdata[`IWC_EXT_FLAG0];
            if (pin1_fall)
                extctl_reg[`IWC_EXT_FLAG1] <= 1'b1;
            else if (ack1)
                extctl_reg[`IWC_EXT_FLAG1] <= 1'b0;
            else if (wr_ext)
                extctl_reg[`IWC_EXT_FLAG1] <= sfr_wdata[`IWC_EXT_FLAG1];
        end
    end

    // Pin flag register: write 0 clears, write 1 keeps; set wins.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            pinflag_reg <= 3'h0;
        else
        begin
            if (pin2_fall)
                pinflag_reg[`IWC_PF_PIN2] <= 1'b1;
            else if (ack_p2 || (wr_flag && !sfr_wdata[`IWC_PF_PIN2]))
                pinflag_reg[`IWC_PF_PIN2] <= 1'b0;
            if (port_change)
                pinflag_reg[`IWC_PF_PORT] <= 1'b1;
            else if (ack_port || (wr_flag && !sfr_wdata[`IWC_PF_PORT]))
                pinflag_reg[`IWC_PF_PORT] <= 1'b0;
            if (timer3_event)
                pinflag_reg[`IWC_PF_TIMER3] <= 1'b1;
            else if (ack_t3 || (wr_flag && !sfr_wdata[`IWC_PF_TIMER3]))
                pinflag_reg[`IWC_PF_TIMER3] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Enable, priority and mask registers.

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            wake_mask_reg <= `IWC_RST_BYTE;
            en_main_reg <= `IWC_RST_BYTE;
            en_extra_reg <= 3'h0;
            plo_main_reg <= 6'h00;
            phi_main_reg <= 6'h00;
            plo_extra_reg <= 3'h0;
            phi_extra_reg <= 3'h0;
        end
        else if (sfr_wr)
        begin
            case (sfr_addr)
                `IWC_ADDR_WAKEMASK: wake_mask_reg <= sfr_wdata;
                `IWC_ADDR_EN_MAIN:
                    en_main_reg <= {sfr_wdata[7], 1'b0, sfr_wdata[5:0]};
                `IWC_ADDR_EN_EXTRA: en_extra_reg <= sfr_wdata[2:0];
                `IWC_ADDR_PLO_MAIN: plo_main_reg <= sfr_wdata[5:0];
                `IWC_ADDR_PHI_MAIN: phi_main_reg <= sfr_wdata[5:0];
                `IWC_ADDR_PLO_EXTRA: plo_extra_reg <= sfr_wdata[2:0];
                `IWC_ADDR_PHI_EXTRA: phi_extra_reg <= sfr_wdata[2:0];
                default: wake_mask_reg <= wake_mask_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power modes.

    // A pin that is low with its enable set refuses Stop entry.
    assign stop_block = (~ext_pin0 & pin0_int_enable) |
                        (~ext_pin1 & pin1_int_enable) |
                        (~ext_pin2 & pin2_int_enable);
    assign wr_power = sfr_wr && sfr_addr == `IWC_ADDR_POWER;

    // Stop wake ignores the global and port change enables.
    assign stop_wake = power_reg[`IWC_PWR_STOP] &
        (stop_block |
         (|((p1_pins ^ p1_ref_reg) & wake_mask_reg)));

    assign cpu_idle = power_reg[`IWC_PWR_SLEEP];
    assign cpu_stop = power_reg[`IWC_PWR_STOP];
    assign power_control_misc = {power_reg[7], power_reg[3:2], 1'b0};

    // Mode requests; Idle ends at once on an enabled request.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            power_reg <= `IWC_RST_BYTE;
            p1_ref_reg <= `IWC_RST_PINS;
            resume_reg <= 4'h0;
        end
        else
        begin
            if (resume_reg != 4'h0)
                resume_reg <= resume_reg - 4'h1;
            if (wr_power)
            begin
                power_reg[7] <= sfr_wdata[7];
                power_reg[3:2] <= sfr_wdata[3:2];
                power_reg[`IWC_PWR_SLEEP] <= sfr_wdata[`IWC_PWR_SLEEP];
                if (!stop_block)
                    power_reg[`IWC_PWR_STOP] <= sfr_wdata[`IWC_PWR_STOP];
                p1_ref_reg <= p1_pins;
            end
            else
            begin
                if (any_idle_wake)
                    power_reg[`IWC_PWR_SLEEP] <= 1'b0;
                if (stop_wake)
                begin
                    power_reg[`IWC_PWR_STOP] <= 1'b0;
                    resume_reg <= `IWC_STOP_RESUME_CYC;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read back, one cycle after the read strobe; unmapped reads zero.

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            sfr_rdata <= `IWC_RST_BYTE;
        else if (sfr_rd)
        begin
            case (sfr_addr)
                `IWC_ADDR_POWER: sfr_rdata <= {power_reg[7], 3'h0,
                    power_reg[3:0]};
                `IWC_ADDR_EXTCTL: sfr_rdata <= {timer_ctl_bits, extctl_reg};
                `IWC_ADDR_PINFLAG: sfr_rdata <= {5'h00, pinflag_reg};
                `IWC_ADDR_WAKEMASK: sfr_rdata <= wake_mask_reg;
                `IWC_ADDR_EN_MAIN: sfr_rdata <= en_main_reg;
                `IWC_ADDR_EN_EXTRA: sfr_rdata <= {5'h00, en_extra_reg};
                `IWC_ADDR_PLO_MAIN: sfr_rdata <= {2'h0, plo_main_reg};
                `IWC_ADDR_PHI_MAIN: sfr_rdata <= {2'h0, phi_main_reg};
                `IWC_ADDR_PLO_EXTRA: sfr_rdata <= {5'h00, plo_extra_reg};
                `IWC_ADDR_PHI_EXTRA: sfr_rdata <= {5'h00, phi_extra_reg};
                default: sfr_rdata <= `IWC_RST_BYTE;
            endcase
        end
    end

endmodule

/* iwc_ctrl_properties.sv */
// Port-level checks on the interrupt and wake-up controller.
// Assumes clk_sys and an active-high reset.
`timescale 1ns/1ps
module iwc_ctrl_checker
(
    // Clock and reset.
    input wire clk_sys,
    input wire reset,
    // Register port.
    input wire [7:0] sfr_addr,
    input wire [7:0] sfr_wdata,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_rdata,
    // Core handshake.
    input wire int_req,
    input wire int_ack,
    input wire [15:0] int_vector,
    input wire [8:0] src_ack,
    // Power modes.
    input wire cpu_idle,
    input wire cpu_stop,
    input wire stop_wake
);
    // All checks on clk_sys, off in reset.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////
    // An accepted request drops and names exactly one source once.
    property p_ack_drop;
        int_req && int_ack |=> !int_req && $onehot(src_ack)
            ##1 src_ack == 9'h000;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack not retired");
    // Vectors are slot*8+3, never the reserved slot.
    property p_vec_form;
        int_req |-> int_vector[15:8] == 8'h00 && int_vector[2:0] == 3'h3
            && int_vector != 16'h0033 && int_vector <= 16'h004B;
    endproperty
    a_vec_form: assert property (p_vec_form)
        else $error("bad vector");
    // Vector 0003 belongs to the first pin.
    property p_vec_pin0;
        int_req && int_ack && int_vector == 16'h0003 |=> src_ack[0];
    endproperty
    a_vec_pin0: assert property (p_vec_pin0)
        else $error("0003 not pin0");
    // Vector 004B belongs to the third pin.
    property p_vec_pin2;
        int_req && int_ack && int_vector == 16'h004B |=> src_ack[8];
    endproperty
    a_vec_pin2: assert property (p_vec_pin2)
        else $error("004B not pin2");
    // A sleep write puts the core to sleep.
    property p_idle_enter;
        sfr_wr && sfr_addr == 8'h87 && sfr_wdata[0] |=> cpu_idle;
    endproperty
    a_idle_enter: assert property (p_idle_enter)
        else $error("no idle");
    // Wake comes only in Stop and ends it next cycle.
    property p_stop_exit;
        stop_wake |-> cpu_stop ##1 !cpu_stop;
    endproperty
    a_stop_exit: assert property (p_stop_exit)
        else $error("bad stop exit");
    // No request in the two cycles after Stop ends.
    property p_stop_hold;
        $fell(cpu_stop) |-> !int_req ##1 !int_req;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("early request");
    // A request leaves Idle in the same cycle it appears.
    property p_idle_wake;
        $rose(int_req) |-> !cpu_idle;
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("still idle");
    // An unmapped address reads as zero.
    property p_unmapped;
        sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read");
endmodule

bind iwc_interrupt_wakeup_ctrl iwc_ctrl_checker i_iwc_ctrl_checker
(
    .clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .int_req(int_req), .int_ack(int_ack),
    .int_vector(int_vector), .src_ack(src_ack), .cpu_idle(cpu_idle),
    .cpu_stop(cpu_stop), .stop_wake(stop_wake)
);

/* iwc_core_model.sv */
// Core model: acks each request after a set wait.
// Assumes int_req stands until acknowledged.
`timescale 1ns/1ps
module iwc_core_model
#(
    parameter [3:0] ACK_WAIT = 4'h0
)
(
    // Clock and reset.
    input wire clk_sys,
    input wire reset,
    // Handshake with the controller.
    input wire int_req,
    output reg int_ack
);
    // Cycles the request has stood unanswered.
    reg [3:0] wait_reg;

    // One-cycle ack once the request has waited.
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            int_ack <= 1'b0;
            wait_reg <= 4'h0;
        end
        else if (int_req && !int_ack && wait_reg == ACK_WAIT)
        begin
            int_ack <= 1'b1;
            wait_reg <= 4'h0;
        end
        else
        begin
            // Count only while a request waits.
            int_ack <= 1'b0;
            wait_reg <= (int_req && !int_ack) ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule

/* iwc_interrupt_wakeup_ctrl_tb_top.sv */
// Self-checking bench for the interrupt and wake-up controller.
// Assumes the core model; the bench drives all sources.
`timescale 1ns/1ps
module iwc_interrupt_wakeup_ctrl_tb_top;
    // Design inputs, all set at time zero.
    reg clk_sys = 1'b0;
    reg reset = 1'b1;
    reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    reg sfr_wr = 1'b0, sfr_rd = 1'b0, int_return = 1'b0;
    reg ext_pin0 = 1'b1, ext_pin1 = 1'b1, ext_pin2 = 1'b1;
    reg [7:0] p1_pins = 8'h00;
    reg timer0_flag = 1'b0, timer1_flag = 1'b0, timer2_flag = 1'b0;
    reg uart_flag = 1'b0, timer3_event = 1'b0;
    // Design outputs.
    wire [7:0] sfr_rdata;
    wire [15:0] int_vector;
    wire [8:0] src_ack;
    wire [1:0] int_level;
    wire int_req, int_ack, cpu_idle, cpu_stop, stop_wake;
    // Run counters and loop variables.
    integer failures = 0, checked = 0, i, n;

    // 100 MHz system clock.
    always #5 clk_sys = ~clk_sys;

    iwc_interrupt_wakeup_ctrl i_iwc_interrupt_wakeup_ctrl
    (
        .clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .ext_pin0(ext_pin0), .ext_pin1(ext_pin1),
        .ext_pin2(ext_pin2), .p1_pins(p1_pins), .timer0_flag(timer0_flag),
        .timer1_flag(timer1_flag), .timer2_flag(timer2_flag),
        .uart_flag(uart_flag), .timer3_event(timer3_event),
        .timer_ctl_bits(4'h0), .int_req(int_req), .int_vector(int_vector),
        .int_level(int_level), .int_ack(int_ack), .int_return(int_return),
        .src_ack(src_ack), .cpu_idle(cpu_idle), .cpu_stop(cpu_stop),
        .stop_wake(stop_wake), .power_control_misc()
    );
    // The core acks two cycles late.
    iwc_core_model #(.ACK_WAIT(4'h2)) i_iwc_core_model
    (
        .clk_sys(clk_sys), .reset(reset), .int_req(int_req),
        .int_ack(int_ack)
    );

    ////////////////////////////////////////////////////////////////////
    // Compare tasks for bytes and for vectors.
    task chk8(input [7:0] got, input [7:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task chk16(input [15:0] got, input [15:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask

    // Register write, strobe up for one edge.
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    end
    endtask
    // Register read, data checked after the edge.
    task rd(input [7:0] a, input [7:0] exp);
    begin
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        chk8(sfr_rdata, exp);
    end
    endtask
    // Handler return pulse.
    task ret;
    begin
        @(posedge clk_sys);
        int_return <= 1'b1;
        @(posedge clk_sys);
        int_return <= 1'b0;
    end
    endtask
    // Release pins, drop peripheral flags.
    task calm;
    begin
        @(posedge clk_sys);
        ext_pin0 <= 1'b1;
        ext_pin1 <= 1'b1;
        ext_pin2 <= 1'b1;
        timer0_flag <= 1'b0;
        timer1_flag <= 1'b0;
        timer2_flag <= 1'b0;
        uart_flag <= 1'b0;
    end
    endtask
    // Raise the event of source s.
    task fire(input integer s);
    begin
        @(posedge clk_sys);
        case (s)
            0: ext_pin0 <= 1'b0;
            1: timer0_flag <= 1'b1;
            2: ext_pin1 <= 1'b0;
            3: timer1_flag <= 1'b1;
            4: uart_flag <= 1'b1;
            5: timer2_flag <= 1'b1;
            6: timer3_event <= 1'b1;
            7: p1_pins[0] <= ~p1_pins[0];
            default: ext_pin2 <= 1'b0;
        endcase
        // Timer3 event is a one-cycle pulse.
        @(posedge clk_sys);
        timer3_event <= 1'b0;
    end
    endtask
    // No request may show in k cycles.
    task quiet(input integer k);
    begin
        n = 0;
        repeat (k)
        begin
            @(posedge clk_sys);
            #1;
            if (int_req === 1'b1)
                n = n + 1;
        end
        chk8(n[7:0], 8'h00);
    end
    endtask
    // Await source s, check it, end its event.
    task take(input integer s, input [1:0] lvl, input r);
    begin
        n = 0;
        while (int_req !== 1'b1 && n < 40)
        begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
        n = (s < 6) ? s : s + 1;
        chk16(int_vector, {8'h00, n[4:0], 3'h3});
        chk8({6'h00, int_level}, {6'h00, lvl});
        n = 0;
        while (src_ack === 9'h000 && n < 40)
        begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
        chk16({7'h00, src_ack}, 16'h0001 << s);
        calm;
        if (r)
            ret;
    end
    endtask

    // Report counts and verdict, then stop.
    task close_out;
    begin
        $display("Comparisons %0d, mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask

    // Watchdog: tests need under a tenth of this.
    initial
    begin
        #400000;
        failures = failures + 1;
        close_out;
    end

    ////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(8'h96, 8'h00);
        rd(8'h00, 8'h00);
        // Edge flag sets with enables off.
        wr(8'h88, 8'h05);
        fire(0);
        quiet(6);
        rd(8'h88, 8'h07);
        wr(8'hA8, 8'h81);
        take(0, 2'd0, 1'b1);
        rd(8'h88, 8'h05);
        // Every source in turn; reserved bits read 0.
        wr(8'hA8, 8'hBF);
        wr(8'hA9, 8'hFF);
        rd(8'hA9, 8'h07);
        wr(8'h96, 8'h01);
        for (i = 0; i < 9; i = i + 1)
        begin
            fire(i);
            take(i, 2'd0, 1'b1);
        end
        // Nesting: level 2 preempts level 0, equal level waits.
        wr(8'hB9, 8'h02);
        fire(4);
        take(4, 2'd0, 1'b0);
        fire(1);
        take(1, 2'd2, 1'b0);
        fire(0);
        quiet(6);
        ret;
        quiet(6);
        ret;
        take(0, 2'd0, 1'b1);
        // Flag register: masked port pin, write-zero clears.
        wr(8'hA9, 8'h00);
        wr(8'h96, 8'h00);
        fire(7);
        fire(8);
        calm;
        rd(8'h95, 8'h04);
        wr(8'h96, 8'h01);
        fire(7);
        rd(8'h95, 8'h06);
        wr(8'h95, 8'hFD);
        rd(8'h95, 8'h04);
        wr(8'h95, 8'hFB);
        rd(8'h95, 8'h00);
        // Idle: disabled source sleeps, low level wakes.
        wr(8'h88, 8'h04);
        wr(8'hA8, 8'h81);
        wr(8'h87, 8'h01);
        fire(1);
        quiet(6);
        chk8({7'h00, cpu_idle}, 8'h01);
        fire(0);
        take(0, 2'd0, 1'b1);
        #1 chk8({7'h00, cpu_idle}, 8'h00);
        // Stop: refused with enabled pin low, woken without global.
        wr(8'h88, 8'h05);
        wr(8'hA8, 8'h01);
        fire(0);
        wr(8'h87, 8'h02);
        rd(8'h87, 8'h00);
        calm;
        wr(8'h87, 8'h02);
        rd(8'h87, 8'h02);
        fire(2);
        #1 chk8({7'h00, cpu_stop}, 8'h01);
        fire(0);
        quiet(6);
        chk8({7'h00, cpu_stop}, 8'h00);
        close_out;
    end
endmodule
